// file: design/aocc_channel.sv
/*
 * audio output channel control: sample queue, d/a update pacing with suspend,
 * update toggle, voice activity flag, and a copy of every channel zero d/a code to the serial sender.
 * assumes samples come from the synthesis core on i_clock, and that the hold and
 * permit pins are asynchronous to it.
 */
`timescale 1ns/10ps
`include "aocc_consts.svh"

module aocc_channel #(
    parameter int QUEUE_DEPTH = `AOCC_QUEUE_DEPTH,
    parameter int UPDATE_CYCLES = `AOCC_UPDATE_CYCLES,
    parameter int BIT_CYCLES = `AOCC_BIT_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // sample stream from the synthesis core
    input wire logic i_sample_valid,
    input wire logic [`AOCC_SAMPLE_W-1:0] i_sample_data,
    output logic o_sample_ready,
    // voice flag configuration and program command
    input wire logic i_flag_manual,
    input wire logic i_flag_command,
    input wire logic i_flag_active_low,
    // channel zero pins
    input wire logic i_playback_hold_n_0,
    output logic [`AOCC_SAMPLE_W-1:0] o_analog_channel_out_0,
    output logic o_sample_update_toggle_0,
    output logic o_voice_active_flag_0,
    // channel one pins, reserved
    input wire logic i_playback_hold_n_1,
    output logic [`AOCC_SAMPLE_W-1:0] o_analog_channel_out_1,
    output logic o_sample_update_toggle_1,
    output logic o_voice_active_flag_1,
    // serial sample link
    input wire logic i_sample_send_permit_n,
    output logic o_serial_sample_out
);
    localparam int PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int DW = (UPDATE_CYCLES > 1) ? $clog2(UPDATE_CYCLES) : 1;

    typedef struct packed {
        logic [1:0] hold_sync;
        logic [QUEUE_DEPTH-1:0][`AOCC_SAMPLE_W-1:0] queue;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic ready;
        logic [DW-1:0] div;
        aocc_pkg::aocc_sample_t dac;
        logic toggle;
        logic playing;
        logic flag;
        logic tx_valid;
        aocc_pkg::aocc_sample_t tx_data;
        aocc_pkg::aocc_sample_t dac_1;
        logic flag_1;
        logic toggle_1;
    } aocc_chan_s;

    aocc_chan_s r;
    aocc_chan_s next_r;
    aocc_stream_if link ();

    logic push;
    logic tick;
    logic pop;
    logic active;
    aocc_pkg::aocc_flag_mode_e flag_mode;

    assign flag_mode = i_flag_manual ? aocc_pkg::AOCC_FLAG_MANUAL : aocc_pkg::AOCC_FLAG_AUTO;

    always_comb begin
        next_r = r;
        next_r.tx_valid = 1'b0;
        next_r.hold_sync = {r.hold_sync[0], i_playback_hold_n_0};

        // intake never looks at the hold pin, so queuing goes on while held
        push = i_sample_valid && r.ready;
        tick = (r.div == '0);
        // the queue head is only consumed by an update that really happens
        pop = tick && r.hold_sync[1] && (r.count != '0);

        // pacing keeps running while held; only the update itself is withheld
        if (tick) begin
            next_r.div = DW'(UPDATE_CYCLES - 1);
        end else begin
            next_r.div = r.div - 1'b1;
        end

        if (push) begin
            next_r.queue[r.wr_ptr] = i_sample_data;
            if (r.wr_ptr == PW'(QUEUE_DEPTH - 1)) begin
                next_r.wr_ptr = '0;
            end else begin
                next_r.wr_ptr = r.wr_ptr + 1'b1;
            end
        end

        // d/a update only while the hold pin is high
        if (tick && r.hold_sync[1]) begin
            if (pop) begin
                next_r.dac = r.queue[r.rd_ptr];
                next_r.playing = 1'b1;
                if (r.rd_ptr == PW'(QUEUE_DEPTH - 1)) begin
                    next_r.rd_ptr = '0;
                end else begin
                    next_r.rd_ptr = r.rd_ptr + 1'b1;
                end
            end else begin
                // nothing queued: rest at mid-scale
                next_r.dac = `AOCC_MID_SCALE;
                next_r.playing = 1'b0;
            end
            next_r.toggle = ~r.toggle;
            // the serial copy is taken from the same code the d/a gets
            next_r.tx_valid = 1'b1;
            next_r.tx_data = next_r.dac;
        end

        unique case ({push, pop})
            2'b10: next_r.count = r.count + 1'b1;
            2'b01: next_r.count = r.count - 1'b1;
            default: next_r.count = r.count;
        endcase
        // registered ready, so a full queue refuses the very next offer
        next_r.ready = (next_r.count != (PW + 1)'(QUEUE_DEPTH));

        // activity: a sample on the d/a or samples still waiting
        active = next_r.playing || (next_r.count != '0);
        unique case (flag_mode)
            aocc_pkg::AOCC_FLAG_AUTO: next_r.flag = active ^ i_flag_active_low;
            aocc_pkg::AOCC_FLAG_MANUAL: next_r.flag = i_flag_command ^ i_flag_active_low;
        endcase

        // reserved channel: mid-scale, no toggle, flag at its inactive level
        next_r.dac_1 = `AOCC_MID_SCALE;
        next_r.flag_1 = i_flag_active_low;
        // kept in a flop so every pin of the block leaves a register
        next_r.toggle_1 = 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
            r.hold_sync <= `AOCC_HOLD_RESET;
            r.dac <= `AOCC_MID_SCALE;
            r.dac_1 <= `AOCC_MID_SCALE;
        end else begin
            r <= next_r;
        end
    end

    assign link.valid = r.tx_valid;
    assign link.data = r.tx_data;

    // frames longer than an update period simply lose the older pending code
    aocc_serial_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_serial (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_sample_send_permit_n(i_sample_send_permit_n),
        .s_in(link.snk),
        .o_serial_sample_out(o_serial_sample_out)
    );

    assign o_sample_ready = r.ready;
    assign o_analog_channel_out_0 = r.dac;
    assign o_sample_update_toggle_0 = r.toggle;
    assign o_voice_active_flag_0 = r.flag;
    // channel one hold pin is read by nothing
    assign o_analog_channel_out_1 = r.dac_1;
    assign o_sample_update_toggle_1 = r.toggle_1;
    assign o_voice_active_flag_1 = r.flag_1;
endmodule

// file: inc/aocc_consts.svh
/*
 * timing, reset and code constants for the audio output channel control block.
 * assumes a 10 MHz core clock; included by bare name from the package and modules.
 */
`ifndef AOCC_CONSTS_SVH
`define AOCC_CONSTS_SVH

`define AOCC_CLK_HZ 10000000
`define AOCC_CLK_PERIOD_NS 100
`define AOCC_SAMPLE_RATE_HZ 8000
`define AOCC_UPDATE_CYCLES (`AOCC_CLK_HZ / `AOCC_SAMPLE_RATE_HZ)
`define AOCC_BIT_TIME_NS 1000
`define AOCC_BIT_CYCLES ((`AOCC_BIT_TIME_NS + `AOCC_CLK_PERIOD_NS - 1) / `AOCC_CLK_PERIOD_NS)
`define AOCC_QUEUE_DEPTH 4
`define AOCC_SAMPLE_W 8
`define AOCC_MID_SCALE 8'h80
`define AOCC_LINE_IDLE 1'b1
`define AOCC_START_BIT 1'b0
`define AOCC_STOP_BIT 1'b1
`define AOCC_HOLD_RESET 2'h3
`define AOCC_PERMIT_RESET 2'h3

`endif

// file: inc/aocc_pkg.sv
/*
 * shared types of the audio output channel control block.
 * assumes aocc_consts.svh is on the include path.
 */
`include "aocc_consts.svh"

package aocc_pkg;
    typedef logic [`AOCC_SAMPLE_W-1:0] aocc_sample_t;

    typedef enum logic {
        AOCC_FLAG_AUTO,
        AOCC_FLAG_MANUAL
    } aocc_flag_mode_e;

    typedef enum logic [1:0] {
        AOCC_TX_IDLE,
        AOCC_TX_START,
        AOCC_TX_DATA,
        AOCC_TX_STOP
    } aocc_tx_state_e;
endpackage

// file: inc/aocc_stream_if.sv
/*
 * sample hand-off from the channel controller to the serial sender.
 * assumes both ends share one clock; valid is a one-cycle pulse.
 */
`timescale 1ns/10ps

interface aocc_stream_if;
    logic valid;
    aocc_pkg::aocc_sample_t data;
    logic busy;

    modport src (
        output valid,
        output data,
        input busy
    );
    modport snk (
        input valid,
        input data,
        output busy
    );
endinterface

// file: design/aocc_serial_tx.sv
/*
 * serial sender: start bit, eight data bits lsb first, stop bit.
 * assumes samples arrive as pulses from the channel controller on the same clock.
 */
`timescale 1ns/10ps
`include "aocc_consts.svh"

module aocc_serial_tx #(
    parameter int BIT_CYCLES = `AOCC_BIT_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // pin from the far side, active low permit
    input wire logic i_sample_send_permit_n,
    // samples from the controller
    aocc_stream_if.snk s_in,
    // serial pin
    output logic o_serial_sample_out
);
    localparam int BW = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;

    typedef struct packed {
        logic [1:0] permit_sync;
        aocc_pkg::aocc_tx_state_e state;
        aocc_pkg::aocc_sample_t hold;
        logic pending;
        aocc_pkg::aocc_sample_t shift;
        logic [2:0] bit_idx;
        logic [BW-1:0] bit_cnt;
        logic line;
    } aocc_tx_s;

    aocc_tx_s r;
    aocc_tx_s next_r;

    always_comb begin
        next_r = r;
        next_r.permit_sync = {r.permit_sync[0], i_sample_send_permit_n};
        // one sample waits here; a newer one replaces it so the link never lags audio
        if (s_in.valid) begin
            next_r.hold = s_in.data;
            next_r.pending = 1'b1;
        end
        unique case (r.state)
            aocc_pkg::AOCC_TX_IDLE: begin
                next_r.line = `AOCC_LINE_IDLE;
                // a frame starts only while the permit is low
                if (r.pending && !r.permit_sync[1]) begin
                    next_r.shift = r.hold;
                    next_r.pending = s_in.valid;
                    next_r.state = aocc_pkg::AOCC_TX_START;
                    next_r.line = `AOCC_START_BIT;
                    next_r.bit_cnt = BW'(BIT_CYCLES - 1);
                end
            end
            aocc_pkg::AOCC_TX_START, aocc_pkg::AOCC_TX_DATA: begin
                if (r.bit_cnt != '0) begin
                    next_r.bit_cnt = r.bit_cnt - 1'b1;
                end else begin
                    next_r.bit_cnt = BW'(BIT_CYCLES - 1);
                    if (r.state == aocc_pkg::AOCC_TX_START) begin
                        next_r.state = aocc_pkg::AOCC_TX_DATA;
                        next_r.bit_idx = 3'h0;
                        next_r.line = r.shift[0];
                    end else if (r.bit_idx == 3'h7) begin
                        next_r.state = aocc_pkg::AOCC_TX_STOP;
                        next_r.line = `AOCC_STOP_BIT;
                    end else begin
                        next_r.bit_idx = r.bit_idx + 3'h1;
                        next_r.line = r.shift[r.bit_idx + 3'h1];
                    end
                end
            end
            aocc_pkg::AOCC_TX_STOP: begin
                if (r.bit_cnt != '0) begin
                    next_r.bit_cnt = r.bit_cnt - 1'b1;
                end else begin
                    next_r.state = aocc_pkg::AOCC_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
            r.permit_sync <= `AOCC_PERMIT_RESET;
            r.state <= aocc_pkg::AOCC_TX_IDLE;
            r.line <= `AOCC_LINE_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign s_in.busy = (r.state != aocc_pkg::AOCC_TX_IDLE);
    assign o_serial_sample_out = r.line;
endmodule

// file: sim/aocc_channel_properties.sv
/* pin checker of the audio channel, with its bind.
   assumes aocc_channel built with short sim counts. */
`timescale 1ns/10ps
module aocc_channel_properties #(
    parameter int UPDATE_CYCLES = 8,
    parameter int BIT_CYCLES = 2
) (
    // watched pins
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_sample_valid,
    input wire logic o_sample_ready,
    input wire logic i_flag_manual,
    input wire logic i_flag_command,
    input wire logic i_flag_active_low,
    input wire logic i_playback_hold_n_0,
    input wire logic [7:0] o_analog_channel_out_0,
    input wire logic o_sample_update_toggle_0,
    input wire logic o_voice_active_flag_0,
    input wire logic [7:0] o_analog_channel_out_1,
    input wire logic o_sample_update_toggle_1,
    input wire logic o_voice_active_flag_1,
    input wire logic i_sample_send_permit_n,
    input wire logic o_serial_sample_out
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    int gap;
    int calm;
    // gap starts so the first update after reset counts as a whole period
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap <= UPDATE_CYCLES - 2;
            calm <= 0;
        end else begin
            gap <= $changed(o_sample_update_toggle_0) ? 0 : gap + 1;
            calm <= i_sample_send_permit_n ? calm + 1 : 0;
        end
    end
    sequence held_s;
        !i_playback_hold_n_0 [*3];
    endsequence
    sequence took_s;
        i_sample_valid && o_sample_ready && !i_flag_manual;
    endsequence
    hold_freeze_a: assert property (held_s |=> $stable(o_sample_update_toggle_0))
        else $error("update while held");
    update_gap_a: assert property ($changed(o_sample_update_toggle_0) |->
        (gap + 1) % UPDATE_CYCLES == 0) else $error("update off period");
    code_tick_a: assert property ($changed(o_analog_channel_out_0) |->
        $changed(o_sample_update_toggle_0)) else $error("code moved without update");
    spare_quiet_a: assert property (o_analog_channel_out_1 == 8'h80
        && !o_sample_update_toggle_1) else $error("spare channel active");
    spare_flag_a: assert property ($past(i_arst_n) |->
        o_voice_active_flag_1 == $past(i_flag_active_low)) else $error("spare flag active");
    manual_flag_a: assert property ($past(i_arst_n) && $past(i_flag_manual) |->
        o_voice_active_flag_0 == ($past(i_flag_command) ^ $past(i_flag_active_low)))
        else $error("manual flag wrong");
    auto_flag_a: assert property (took_s |=>
        o_voice_active_flag_0 == !$past(i_flag_active_low)) else $error("flag not raised");
    ready_cause_a: assert property ($fell(o_sample_ready) |->
        $past(i_sample_valid) || $past(i_sample_valid, 2)) else $error("ready fell alone");
    permit_idle_a: assert property (calm > 10 * BIT_CYCLES + 6 |->
        o_serial_sample_out) else $error("sent without permit");
endmodule

bind aocc_channel aocc_channel_properties #(
    .UPDATE_CYCLES(UPDATE_CYCLES),
    .BIT_CYCLES(BIT_CYCLES)
) aocc_channel_properties_inst (.*);

// file: sim/aocc_far_side.sv
/* far side of the serial link: frame receiver and permit driver.
   assumes frames of start, 8 bits lsb first, stop, BIT_CYCLES each. */
`timescale 1ns/10ps
module aocc_far_side #(
    parameter int BIT_CYCLES = 2
) (
    // clock, line and pacing
    input wire logic i_clock,
    input wire logic i_serial_sample_out,
    input wire logic i_slow,
    // permit to the sender
    output logic o_sample_send_permit_n
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    int rx_n = 0;
    int seen = 0;
    int stop_bad = 0;
    initial o_sample_send_permit_n = 1'b0;
    // bits read on the falling edge, half a cycle into each bit and clear of the sender's edge
    always begin
        @(negedge i_clock);
        if (i_serial_sample_out === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(negedge i_clock);
                b[i] = i_serial_sample_out;
            end
            repeat (BIT_CYCLES) @(negedge i_clock);
            if (i_serial_sample_out !== 1'b1) stop_bad++;
            rx_q.push_back(b);
            rx_n++;
        end
    end
    // a slow amplifier pauses the link after each frame, still listening
    always @(posedge i_clock) if (i_slow && rx_n != seen) begin
        seen = rx_n;
        #1 o_sample_send_permit_n = 1'b1;
        repeat (30) @(posedge i_clock);
        #1 o_sample_send_permit_n = 1'b0;
    end
endmodule

// file: sim/tb.sv
/* self-checking bench of the audio channel.
   assumes the far-side model and the pin checker bound to the design. */
`timescale 1ns/10ps
module tb;
    localparam int UPD = 8;
    logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, man = 1'b0, cmd = 1'b0, al = 1'b0;
    logic hold0 = 1'b1, hold1 = 1'b1, slow = 1'b0, last = 1'b0, t;
    logic rdy, tog0, tog1, flag0, flag1, permit_n, ser;
    logic [7:0] data = 8'h00, ana0, ana1, e, r;
    logic [31:0] seed = 32'h43f316ed;
    logic [7:0] exp_q[$], sent_q[$], pend[$];
    int err_count = 0, n_tests = 0, n0;
    always #50 clk = ~clk;
    aocc_channel #(.QUEUE_DEPTH(4), .UPDATE_CYCLES(UPD), .BIT_CYCLES(2)) aocc_channel_inst (
        .i_clock(clk), .i_arst_n(rst_n), .i_sample_valid(valid), .i_sample_data(data),
        .o_sample_ready(rdy), .i_flag_manual(man), .i_flag_command(cmd),
        .i_flag_active_low(al), .i_playback_hold_n_0(hold0), .o_analog_channel_out_0(ana0),
        .o_sample_update_toggle_0(tog0), .o_voice_active_flag_0(flag0),
        .i_playback_hold_n_1(hold1), .o_analog_channel_out_1(ana1),
        .o_sample_update_toggle_1(tog1), .o_voice_active_flag_1(flag1),
        .i_sample_send_permit_n(permit_n), .o_serial_sample_out(ser));
    aocc_far_side #(.BIT_CYCLES(2)) aocc_far_side_inst (.i_clock(clk),
        .i_serial_sample_out(ser), .i_slow(slow), .o_sample_send_permit_n(permit_n));
    function automatic logic [31:0] step(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(logic [7:0] got, logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // valid stays up across a burst so it is never dropped and raised in one step
    task automatic push(int n);
        int k;
        for (int i = 0; i < n; i++) begin
            seed = step(seed);
            data = seed[7:0];
            valid = 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (rdy !== 1'b1 && k < 400);
            if (k >= 400) begin
                err_count++;
                wrap_up();
            end
            #1;
        end
        valid = 1'b0;
    endtask
    // takes of an edge join the model only after that edge's update is scored
    always @(posedge clk) if (valid && rdy === 1'b1 && rst_n) pend.push_back(data);
    always @(negedge clk) begin
        if (tog0 !== last) begin
            last = tog0;
            e = exp_q.size() ? exp_q.pop_front() : 8'h80;
            check(ana0, e);
            sent_q.push_back(e);
        end
        while (pend.size()) exp_q.push_back(pend.pop_front());
    end
    // a newer code may overwrite a pending one, so frames form a subsequence
    always @(negedge clk) if (aocc_far_side_inst.rx_q.size()) begin
        r = aocc_far_side_inst.rx_q.pop_front();
        while (sent_q.size() && sent_q[0] !== r) void'(sent_q.pop_front());
        check(sent_q.size() ? r : ~r, r);
        if (sent_q.size()) void'(sent_q.pop_front());
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(2);
        push(6);
        cyc(8 * UPD);
        hold0 = 1'b0;
        cyc(3);
        t = tog0;
        n0 = aocc_far_side_inst.rx_n;
        push(4);
        cyc(40);
        check(rdy, 1'b0);
        check(tog0, t);
        check(8'(aocc_far_side_inst.rx_n > n0), 8'h01);
        hold0 = 1'b1;
        cyc(6 * UPD);
        slow = 1'b1;
        for (int i = 0; i < 6; i++) begin
            hold1 = seed[3];
            push(3);
            cyc(UPD);
        end
        slow = 1'b0;
        cyc(10 * UPD);
        for (int i = 0; i < 8; i++) begin
            {man, cmd, al} = 3'(i);
            cyc(2);
            if (man) check(flag0, cmd ^ al);
            else begin
                push(1);
                cyc(1);
                check(flag0, !al);
                cyc(4 * UPD);
                check(flag0, al);
            end
            check(flag1, al);
            check(ana1, 8'h80);
            check(tog1, 1'b0);
        end
        check(8'(aocc_far_side_inst.stop_bad), 8'h00);
        wrap_up();
    end
endmodule
